// file: logic/tse_exec.sv
// Execution unit for conditional traps and system-control operations.
// Assumes one decoded op per cycle from the pipeline, same clock, with
// operands already read; every op completes in a single cycle.
// Functional notes
// - Register ge trap fires when rs is not below rt, signed or unsigned.
// - Register lt trap fires when rs is below rt, signed or unsigned.
// - Equal trap fires on identical registers, not-equal trap otherwise.
// - Signed ge immediate trap fires when rs >= sign-extended immediate.
// - Signed lt immediate trap fires when rs < sign-extended immediate.
// - Unsigned immediate traps compare unsigned to the sign-extended immediate.
// - Equal-imm trap fires on a match, not-equal-imm trap on a mismatch.
// - Word move-to copies a CPU register word into a system-control reg.
// - Word move-from copies a system-control word into a CPU register.
// - Doubleword move-to copies all 64 bits into a system-control reg.
// - Doubleword move-from copies all 64 bits into a CPU register.
// - TLB read loads the entry at the TLB pointer into the staging regs.
// - Indexed TLB write stores the staging registers at the TLB pointer.
// - Random TLB write puts the staging regs at the replacement pointer.
// - TLB probe finds the staging tag and stores the match position.
// - Exception return ends the handler and resumes the interrupted code.
`timescale 1ns/1ps
`include "tse_regs.svh"

module tse_exec (
  input wire logic SYS_CLK, // 200 MHz clock
  input wire logic RST_N, // Synchronous reset, active low
  input wire logic OP_VALID, // Decoded op present this cycle
  input wire tse_pkg::tse_op_e OP_CODE, // Decoded operation
  input wire logic [`TSE_DW-1:0] RS_DATA, // rs operand
  input wire logic [`TSE_DW-1:0] RT_DATA, // rt operand
  input wire logic [`TSE_IMM_W-1:0] IMM_DATA, // Immediate field
  input wire logic [`TSE_SEL_W-1:0] GPR_SEL, // CPU register number rt
  input wire logic [`TSE_SEL_W-1:0] SYS_SEL, // System-control reg rd
  input wire logic [`TSE_DW-1:0] INSTR_PC, // Address of this op
  output logic TRAP_RAISE, // Trap exception pulse
  output logic GPR_WE, // CPU register write pulse
  output logic [`TSE_SEL_W-1:0] GPR_WADDR, // CPU register number
  output logic [`TSE_DW-1:0] GPR_WDATA, // CPU register data
  output logic RESUME_VALID, // Return-from-exception pulse
  output logic [`TSE_DW-1:0] RESUME_PC, // Resume address
  output logic EXC_LEVEL, // Exception level bit
  output logic ERR_LEVEL, // Error level bit
  output logic PROBE_MISS // Last probe found no entry
);

  logic [`TSE_DW-1:0] tlb_tag [`TSE_TLB_N];
  logic [`TSE_DW-1:0] tlb_even [`TSE_TLB_N];
  logic [`TSE_DW-1:0] tlb_odd [`TSE_TLB_N];
  logic [`TSE_DW-1:0] tlb_mask [`TSE_TLB_N];

  logic [`TSE_DW-1:0] index_r;
  logic [`TSE_IDX_W-1:0] random_r;
  logic [`TSE_DW-1:0] tag_r;
  logic [`TSE_DW-1:0] even_r;
  logic [`TSE_DW-1:0] odd_r;
  logic [`TSE_DW-1:0] mask_r;
  logic [`TSE_DW-1:0] status_r;
  logic [`TSE_DW-1:0] epc_r;
  logic [`TSE_DW-1:0] err_epc_r;

  logic trap_is;
  logic trap_hit;
  logic fire;
  logic mv_to;
  logic mv_from;
  logic [`TSE_DW-1:0] wdata;
  logic [`TSE_DW-1:0] rdata;
  logic [`TSE_DW-1:0] rdata_ext;
  logic [`TSE_IDX_W-1:0] idx;
  logic [`TSE_TLB_N-1:0] match;
  logic probe_found;
  logic [`TSE_IDX_W-1:0] probe_pos;

  assign fire = OP_VALID;
  assign idx = index_r[`TSE_IDX_W-1:0];
  assign mv_to = fire && (OP_CODE == tse_pkg::TSE_MOVE_WORD_TO_SYSCTL ||
                 OP_CODE == tse_pkg::TSE_MOVE_DWORD_TO_SYSCTL);
  assign mv_from = fire && (OP_CODE == tse_pkg::TSE_MOVE_WORD_FROM_SYSCTL ||
                   OP_CODE == tse_pkg::TSE_MOVE_DWORD_FROM_SYSCTL);

  tse_trap_eval u_eval (
    .op(OP_CODE),
    .rs_val(RS_DATA),
    .rt_val(RT_DATA),
    .imm(IMM_DATA),
    .is_trap(trap_is),
    .hit(trap_hit)
  );

  // Word moves carry the low word, sign-extended to the full register
  assign wdata = (OP_CODE == tse_pkg::TSE_MOVE_WORD_TO_SYSCTL) ?
    {{32{RT_DATA[31]}}, RT_DATA[31:0]} : RT_DATA;

  always_comb begin
    if (SYS_SEL == `TSE_REG_INDEX) begin
      rdata = index_r;
    end else if (SYS_SEL == `TSE_REG_RANDOM) begin
      rdata = {{(`TSE_DW-`TSE_IDX_W){1'b0}}, random_r};
    end else if (SYS_SEL == `TSE_REG_EVEN) begin
      rdata = even_r;
    end else if (SYS_SEL == `TSE_REG_ODD) begin
      rdata = odd_r;
    end else if (SYS_SEL == `TSE_REG_MASK) begin
      rdata = mask_r;
    end else if (SYS_SEL == `TSE_REG_TAG) begin
      rdata = tag_r;
    end else if (SYS_SEL == `TSE_REG_STATUS) begin
      rdata = status_r;
    end else if (SYS_SEL == `TSE_REG_EPC) begin
      rdata = epc_r;
    end else if (SYS_SEL == `TSE_REG_ERR_EPC) begin
      rdata = err_epc_r;
    end else begin
      rdata = '0;
    end
  end

  assign rdata_ext = (OP_CODE == tse_pkg::TSE_MOVE_WORD_FROM_SYSCTL) ?
    {{32{rdata[31]}}, rdata[31:0]} : rdata;

  // Page-mask bits widen the ignored span of the page number
  genvar g;
  generate
    for (g = 0; g < `TSE_TLB_N; g++) begin : g_probe
      logic [`TSE_DW-1:0] care;
      logic asid_ok;
      assign care = ~tlb_mask[g] &
                    ({`TSE_DW{1'b1}} << `TSE_VPN_LSB);
      assign asid_ok = (tlb_even[g][`TSE_GLOBAL_BIT] &&
                        tlb_odd[g][`TSE_GLOBAL_BIT]) ||
                       (tlb_tag[g][`TSE_ASID_W-1:0] ==
                        tag_r[`TSE_ASID_W-1:0]);
      assign match[g] = asid_ok && (((tlb_tag[g] ^ tag_r) & care) == '0);
    end
  endgenerate

  // Lowest matching entry wins; software must avoid duplicate entries
  always_comb begin
    probe_found = 1'b0;
    probe_pos = '0;
    for (int i = `TSE_TLB_N - 1; i >= 0; i--) begin
      if (match[i]) begin
        probe_found = 1'b1;
        probe_pos = `TSE_IDX_W'(i);
      end
    end
  end

  // Pulse outputs toward the pipeline
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      TRAP_RAISE <= 1'b0;
      GPR_WE <= 1'b0;
      GPR_WADDR <= '0;
      GPR_WDATA <= '0;
    end else begin
      TRAP_RAISE <= fire && trap_is && trap_hit;
      GPR_WE <= mv_from;
      if (mv_from) begin
        GPR_WADDR <= GPR_SEL;
        GPR_WDATA <= rdata_ext;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      RESUME_VALID <= 1'b0;
      RESUME_PC <= '0;
    end else begin
      RESUME_VALID <= fire && OP_CODE == tse_pkg::TSE_EXCEPTION_RETURN_OP;
      if (fire && OP_CODE == tse_pkg::TSE_EXCEPTION_RETURN_OP) begin
        RESUME_PC <= status_r[`TSE_ERL_BIT] ? err_epc_r : epc_r;
      end
    end
  end

  // Replacement pointer steps every cycle so its choice looks random
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      random_r <= `TSE_RANDOM_RST;
    end else if (random_r == `TSE_RANDOM_LAST) begin
      random_r <= `TSE_RANDOM_RST;
    end else begin
      random_r <= random_r - 5'h01;
    end
  end

  // TLB array has no reset; software must write every entry before use
  always_ff @(posedge SYS_CLK) begin
    if (fire && OP_CODE == tse_pkg::TSE_TLB_WRITE_INDEXED_OP) begin
      tlb_tag[idx] <= tag_r;
      tlb_even[idx] <= even_r;
      tlb_odd[idx] <= odd_r;
      tlb_mask[idx] <= mask_r;
    end else if (fire && OP_CODE == tse_pkg::TSE_TLB_WRITE_RANDOM_OP) begin
      tlb_tag[random_r] <= tag_r;
      tlb_even[random_r] <= even_r;
      tlb_odd[random_r] <= odd_r;
      tlb_mask[random_r] <= mask_r;
    end
  end

  // System-control registers
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      index_r <= '0;
      tag_r <= '0;
      even_r <= '0;
      odd_r <= '0;
      mask_r <= '0;
      status_r <= `TSE_STATUS_RST;
      epc_r <= '0;
      err_epc_r <= '0;
    end else if (mv_to) begin
      if (SYS_SEL == `TSE_REG_INDEX) begin
        index_r <= wdata;
      end else if (SYS_SEL == `TSE_REG_EVEN) begin
        even_r <= wdata;
      end else if (SYS_SEL == `TSE_REG_ODD) begin
        odd_r <= wdata;
      end else if (SYS_SEL == `TSE_REG_MASK) begin
        mask_r <= wdata;
      end else if (SYS_SEL == `TSE_REG_TAG) begin
        tag_r <= wdata;
      end else if (SYS_SEL == `TSE_REG_STATUS) begin
        status_r <= wdata;
      end else if (SYS_SEL == `TSE_REG_EPC) begin
        epc_r <= wdata;
      end else if (SYS_SEL == `TSE_REG_ERR_EPC) begin
        err_epc_r <= wdata;
      end
    end else if (fire && OP_CODE == tse_pkg::TSE_TLB_READ_OP) begin
      tag_r <= tlb_tag[idx];
      even_r <= tlb_even[idx];
      odd_r <= tlb_odd[idx];
      mask_r <= tlb_mask[idx];
    end else if (fire && OP_CODE == tse_pkg::TSE_TLB_PROBE_OP) begin
      index_r <= '0;
      index_r[`TSE_PROBE_MISS_BIT] <= !probe_found;
      index_r[`TSE_IDX_W-1:0] <= probe_pos;
    end else if (fire && OP_CODE == tse_pkg::TSE_EXCEPTION_RETURN_OP) begin
      if (status_r[`TSE_ERL_BIT]) begin
        status_r[`TSE_ERL_BIT] <= 1'b0;
      end else begin
        status_r[`TSE_EXL_BIT] <= 1'b0;
      end
    end else if (fire && trap_is && trap_hit) begin
      // Nested traps keep the first return address
      if (!status_r[`TSE_EXL_BIT]) begin
        epc_r <= INSTR_PC;
      end
      status_r[`TSE_EXL_BIT] <= 1'b1;
    end
  end

  assign EXC_LEVEL = status_r[`TSE_EXL_BIT];
  assign ERR_LEVEL = status_r[`TSE_ERL_BIT];
  assign PROBE_MISS = index_r[`TSE_PROBE_MISS_BIT];

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  trap_ge_unsigned_a: assert property (
    OP_VALID && OP_CODE == tse_pkg::TSE_TRAP_GE_UNSIGNED &&
    RS_DATA >= RT_DATA |=> TRAP_RAISE && EXC_LEVEL)
    else $error("unsigned ge trap did not fire");

  trap_lt_signed_a: assert property (
    OP_VALID && OP_CODE == tse_pkg::TSE_TRAP_LT_SIGNED &&
    $signed(RS_DATA) < $signed(RT_DATA) |=> TRAP_RAISE)
    else $error("signed lt trap did not fire");

  trap_equal_a: assert property (
    OP_VALID && OP_CODE == tse_pkg::TSE_TRAP_EQUAL |=>
    TRAP_RAISE == ($past(RS_DATA) == $past(RT_DATA)))
    else $error("equal trap wrong");

  trap_ge_imm_a: assert property (
    OP_VALID && OP_CODE == tse_pkg::TSE_TRAP_GE_IMM_SIGNED &&
    $signed(RS_DATA) >= $signed({{48{IMM_DATA[15]}}, IMM_DATA}) |=> TRAP_RAISE)
    else $error("signed ge imm trap did not fire");

  trap_lt_imm_a: assert property (
    OP_VALID && OP_CODE == tse_pkg::TSE_TRAP_LT_IMM_SIGNED &&
    $signed(RS_DATA) < $signed({{48{IMM_DATA[15]}}, IMM_DATA}) |=> TRAP_RAISE)
    else $error("signed lt imm trap did not fire");

  trap_ltu_imm_a: assert property (
    OP_VALID && OP_CODE == tse_pkg::TSE_TRAP_LT_IMM_UNSIGNED &&
    RS_DATA == 64'h0 && IMM_DATA != 16'h0000 |=> TRAP_RAISE)
    else $error("unsigned lt imm trap did not fire");

  trap_ne_imm_a: assert property (
    OP_VALID && OP_CODE == tse_pkg::TSE_TRAP_NOT_EQUAL_IMM &&
    RS_DATA == {{48{IMM_DATA[15]}}, IMM_DATA} |=> !TRAP_RAISE)
    else $error("not equal imm trap fired on match");

  move_word_to_a: assert property (
    OP_VALID && OP_CODE == tse_pkg::TSE_MOVE_WORD_TO_SYSCTL &&
    SYS_SEL == `TSE_REG_TAG |=> tag_r == $past(wdata) &&
    tag_r[63:32] == {32{tag_r[31]}})
    else $error("word move to sysctl wrong");

  move_dword_from_a: assert property (
    OP_VALID && OP_CODE == tse_pkg::TSE_MOVE_DWORD_FROM_SYSCTL |=>
    GPR_WE && GPR_WADDR == $past(GPR_SEL) && GPR_WDATA == $past(rdata)
    ##1 !GPR_WE || $past(mv_from))
    else $error("dword move from sysctl wrong");

  probe_result_a: assert property (
    OP_VALID && OP_CODE == tse_pkg::TSE_TLB_PROBE_OP && probe_found |=>
    !PROBE_MISS && index_r[`TSE_IDX_W-1:0] == $past(probe_pos))
    else $error("probe position not stored");

  exception_return_op_resume_a: assert property (
    OP_VALID && OP_CODE == tse_pkg::TSE_EXCEPTION_RETURN_OP &&
    !ERR_LEVEL |=> RESUME_VALID && RESUME_PC == $past(epc_r) && !EXC_LEVEL)
    else $error("exception return did not resume");

  trap_quiet_a: assert property (
    OP_VALID && trap_is && !trap_hit |=> !TRAP_RAISE && !GPR_WE &&
    $stable(epc_r) && $stable(status_r))
    else $error("false trap changed state");

endmodule : tse_exec

// file: logic/tse_regs.svh
// Register numbers, field positions and reset values of the trap and
// system-control execution block. Definitions only; included by bare name.
`ifndef TSE_REGS_SVH
`define TSE_REGS_SVH

`define TSE_DW 64
`define TSE_IMM_W 16
`define TSE_SEL_W 5
`define TSE_TLB_N 32
`define TSE_IDX_W 5

// System-control register numbers
`define TSE_REG_INDEX 5'h00
`define TSE_REG_RANDOM 5'h01
`define TSE_REG_EVEN 5'h02
`define TSE_REG_ODD 5'h03
`define TSE_REG_MASK 5'h05
`define TSE_REG_TAG 5'h0a
`define TSE_REG_STATUS 5'h0c
`define TSE_REG_EPC 5'h0e
`define TSE_REG_ERR_EPC 5'h1e

// Field positions
`define TSE_PROBE_MISS_BIT 31
`define TSE_EXL_BIT 1
`define TSE_ERL_BIT 2
`define TSE_GLOBAL_BIT 0
`define TSE_VPN_LSB 13
`define TSE_ASID_W 8

// Reset values
`define TSE_STATUS_RST 64'h0000_0000_0000_0000
`define TSE_RANDOM_RST 5'h1f
`define TSE_RANDOM_LAST 5'h00

`endif

// file: logic/tse_pkg.sv
// Types shared by the trap and system-control execution block.
// Assumes the pipeline presents one decoded operation per cycle.
package tse_pkg;

  typedef enum logic [4:0] {
    TSE_NOP,
    TSE_TRAP_GE_SIGNED,
    TSE_TRAP_GE_UNSIGNED,
    TSE_TRAP_LT_SIGNED,
    TSE_TRAP_LT_UNSIGNED,
    TSE_TRAP_EQUAL,
    TSE_TRAP_NOT_EQUAL,
    TSE_TRAP_GE_IMM_SIGNED,
    TSE_TRAP_GE_IMM_UNSIGNED,
    TSE_TRAP_LT_IMM_SIGNED,
    TSE_TRAP_LT_IMM_UNSIGNED,
    TSE_TRAP_EQUAL_IMM,
    TSE_TRAP_NOT_EQUAL_IMM,
    TSE_MOVE_WORD_TO_SYSCTL,
    TSE_MOVE_WORD_FROM_SYSCTL,
    TSE_MOVE_DWORD_TO_SYSCTL,
    TSE_MOVE_DWORD_FROM_SYSCTL,
    TSE_TLB_READ_OP,
    TSE_TLB_WRITE_INDEXED_OP,
    TSE_TLB_WRITE_RANDOM_OP,
    TSE_TLB_PROBE_OP,
    TSE_EXCEPTION_RETURN_OP
  } tse_op_e;

endpackage : tse_pkg

// file: logic/tse_trap_eval.sv
// Trap condition evaluator: pure combinational compare of a register
// against a register or an extended 16-bit immediate.
// Assumes operands are stable for the cycle in which the op is valid.
`timescale 1ns/1ps
`include "tse_regs.svh"

module tse_trap_eval (
  input wire tse_pkg::tse_op_e op, // Decoded operation
  input wire logic [`TSE_DW-1:0] rs_val, // First source register
  input wire logic [`TSE_DW-1:0] rt_val, // Second source register
  input wire logic [`TSE_IMM_W-1:0] imm, // Immediate field
  output logic is_trap, // Operation is a trap
  output logic hit // Trap condition holds
);

  logic [`TSE_DW-1:0] imm_ext;
  logic [`TSE_DW-1:0] b;
  logic lt_s;
  logic lt_u;
  logic eq;

  // Unsigned immediate forms also sign-extend, then compare unsigned
  assign imm_ext = {{(`TSE_DW-`TSE_IMM_W){imm[`TSE_IMM_W-1]}},
                    imm};
  assign b = (op >= tse_pkg::TSE_TRAP_GE_IMM_SIGNED) ? imm_ext : rt_val;
  assign lt_s = $signed(rs_val) < $signed(b);
  assign lt_u = rs_val < b;
  assign eq = rs_val == b;

  always_comb begin
    is_trap = 1'b1;
    hit = 1'b0;
    case (op)
      tse_pkg::TSE_TRAP_GE_SIGNED: hit = !lt_s;
      tse_pkg::TSE_TRAP_GE_UNSIGNED: hit = !lt_u;
      tse_pkg::TSE_TRAP_LT_SIGNED: hit = lt_s;
      tse_pkg::TSE_TRAP_LT_UNSIGNED: hit = lt_u;
      tse_pkg::TSE_TRAP_EQUAL: hit = eq;
      tse_pkg::TSE_TRAP_NOT_EQUAL: hit = !eq;
      tse_pkg::TSE_TRAP_GE_IMM_SIGNED: hit = !lt_s;
      tse_pkg::TSE_TRAP_LT_IMM_SIGNED: hit = lt_s;
      tse_pkg::TSE_TRAP_GE_IMM_UNSIGNED: hit = !lt_u;
      tse_pkg::TSE_TRAP_LT_IMM_UNSIGNED: hit = lt_u;
      tse_pkg::TSE_TRAP_EQUAL_IMM: hit = eq;
      tse_pkg::TSE_TRAP_NOT_EQUAL_IMM: hit = !eq;
      default: is_trap = 1'b0;
    endcase
  end

endmodule : tse_trap_eval

// file: testbench/tse_pipe_model.sv
// Pipeline-side model: a CPU register file written by the move-from
// results, and a count of trap exceptions that it was asked to take.
// Assumes it shares SYS_CLK and RST_N with the execution unit.
`timescale 1ns/1ps
`include "tse_regs.svh"

module tse_pipe_model (
  input wire logic SYS_CLK, // Clock
  input wire logic RST_N, // Synchronous reset, active low
  input wire logic TRAP_RAISE, // Trap exception pulse
  input wire logic GPR_WE, // CPU register write pulse
  input wire logic [`TSE_SEL_W-1:0] GPR_WADDR, // CPU register number
  input wire logic [`TSE_DW-1:0] GPR_WDATA, // CPU register data
  output logic [15:0] trap_cnt // Exceptions taken so far
);
  logic [`TSE_DW-1:0] gpr [0:31];

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      trap_cnt <= 16'h0000;
    end else if (TRAP_RAISE) begin
      trap_cnt <= trap_cnt + 16'h0001;
    end
  end

  // Register zero stays writable here; the block does not filter it
  always_ff @(posedge SYS_CLK) begin
    if (GPR_WE) begin
      gpr[GPR_WADDR] <= GPR_WDATA;
    end
  end
endmodule : tse_pipe_model

// file: testbench/tb_trap_and_sysctl_instr_exec.sv
// Self-checking bench of the trap and system-control execution unit.
// Ops are issued back to back, one per cycle, 1 ns after each edge;
// results are looked at 1 ns after the edge that takes the op.
`timescale 1ns/1ps
`include "tse_regs.svh"

module tb_trap_and_sysctl_instr_exec;
  logic SYS_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic OP_VALID = 1'b0;
  tse_pkg::tse_op_e OP_CODE = tse_pkg::TSE_NOP;
  logic [63:0] RS_DATA = 64'h0;
  logic [63:0] RT_DATA = 64'h0;
  logic [15:0] IMM_DATA = 16'h0;
  logic [4:0] GPR_SEL = 5'h0;
  logic [4:0] SYS_SEL = 5'h0;
  logic [63:0] INSTR_PC = 64'h0;
  logic TRAP_RAISE, GPR_WE, RESUME_VALID, EXC_LEVEL, ERR_LEVEL, PROBE_MISS;
  logic [4:0] GPR_WADDR;
  logic [63:0] GPR_WDATA, RESUME_PC, epc_exp;
  logic [15:0] trap_cnt;
  logic [63:0] va [0:3];
  logic [63:0] vb [0:3];
  logic [15:0] vi [0:3];
  logic hit, exc_exp;
  logic [4:0] rnd;
  int n_errors = 0;
  int n_checks = 0;
  int n_hits = 0;

  always #2.5 SYS_CLK = ~SYS_CLK;

  tse_exec dut_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .OP_VALID(OP_VALID),
    .OP_CODE(OP_CODE), .RS_DATA(RS_DATA), .RT_DATA(RT_DATA),
    .IMM_DATA(IMM_DATA), .GPR_SEL(GPR_SEL), .SYS_SEL(SYS_SEL),
    .INSTR_PC(INSTR_PC), .TRAP_RAISE(TRAP_RAISE), .GPR_WE(GPR_WE),
    .GPR_WADDR(GPR_WADDR), .GPR_WDATA(GPR_WDATA),
    .RESUME_VALID(RESUME_VALID), .RESUME_PC(RESUME_PC),
    .EXC_LEVEL(EXC_LEVEL), .ERR_LEVEL(ERR_LEVEL), .PROBE_MISS(PROBE_MISS));

  tse_pipe_model model_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .TRAP_RAISE(TRAP_RAISE), .GPR_WE(GPR_WE), .GPR_WADDR(GPR_WADDR),
    .GPR_WDATA(GPR_WDATA), .trap_cnt(trap_cnt));

  task chk(input string what, input logic [63:0] seen,
           input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask : chk

  task finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // Valid stays high: the next call drives the next op in the same step
  task send(input int op, input logic [63:0] rs, input logic [63:0] rt,
            input logic [15:0] imm, input logic [4:0] gs,
            input logic [4:0] ss, input logic [63:0] pc);
    OP_VALID = 1'b1;
    OP_CODE = tse_pkg::tse_op_e'(op);
    RS_DATA = rs;
    RT_DATA = rt;
    IMM_DATA = imm;
    GPR_SEL = gs;
    SYS_SEL = ss;
    INSTR_PC = pc;
    @(posedge SYS_CLK);
    #1;
  endtask : send

  task mt(input logic [4:0] ss, input logic [63:0] d);
    send(15, 64'h0, d, 16'h0, 5'h0, ss, 64'h0);
  endtask : mt

  task mf(input logic [4:0] ss);
    send(16, 64'h0, 64'h0, 16'h0, 5'h3, ss, 64'h0);
  endtask : mf

  // Reference condition, worked out independently of the design
  function automatic logic hit_f(input int op, input logic [63:0] a,
                                 input logic [63:0] b, input logic [15:0] i);
    logic [63:0] s;
    s = {{48{i[15]}}, i};
    case (op)
      1: hit_f = $signed(a) >= $signed(b);
      2: hit_f = a >= b;
      3: hit_f = $signed(a) < $signed(b);
      4: hit_f = a < b;
      5: hit_f = a == b;
      6: hit_f = a != b;
      7: hit_f = $signed(a) >= $signed(s);
      8: hit_f = a >= s;
      9: hit_f = $signed(a) < $signed(s);
      10: hit_f = a < s;
      11: hit_f = a == s;
      default: hit_f = a != s;
    endcase
  endfunction : hit_f

  initial begin
    repeat (20000) @(posedge SYS_CLK);
    n_errors++;
    finish_test();
  end

  initial begin
    va = '{64'hffff_ffff_ffff_ffff, 64'h1, 64'h5, 64'h0};
    vb = '{64'h1, 64'hffff_ffff_ffff_ffff, 64'h5, 64'h1};
    vi = '{16'h0001, 16'hffff, 16'h0005, 16'h8000};
    repeat (20) @(posedge SYS_CLK);
    #1;
    RST_N = 1'b1;
    chk("exc level after reset", EXC_LEVEL, 64'h0);
    chk("probe miss after reset", PROBE_MISS, 64'h0);
    exc_exp = 1'b0;
    for (int op = 1; op <= 12; op++) begin
      for (int k = 0; k < 4; k++) begin
        hit = hit_f(op, va[k], vb[k], vi[k]);
        if (hit && !exc_exp) epc_exp = 64'h100 + 64'(op * 16 + k * 4);
        if (hit) n_hits++;
        exc_exp = exc_exp | hit;
        send(op, va[k], vb[k], vi[k], 5'h0, 5'h0,
             64'h100 + 64'(op * 16 + k * 4));
        if (op < 7)
          chk("reg trap", TRAP_RAISE, hit);
        else
          chk("imm trap", TRAP_RAISE, hit);
        chk("exc level", EXC_LEVEL, exc_exp);
        chk("no write on trap", GPR_WE, 64'h0);
      end
    end
    mf(5'h0e);
    chk("return address", GPR_WDATA, epc_exp);
    chk("move-from dest", GPR_WADDR, 64'h3);
    send(13, 64'h0, 64'h0000_0000_8000_1234, 16'h0, 5'h0, 5'h0a, 64'h0);
    mf(5'h0a);
    chk("word move-to", GPR_WDATA, 64'hffff_ffff_8000_1234);
    mt(5'h02, 64'h1234_5678_9abc_def0);
    send(14, 64'h0, 64'h0, 16'h0, 5'h07, 5'h02, 64'h0);
    chk("word move-from", GPR_WDATA, 64'hffff_ffff_9abc_def0);
    chk("word move-from dest", GPR_WADDR, 64'h7);
    chk("write pulse", GPR_WE, 64'h1);
    mf(5'h02);
    chk("dword move-to", GPR_WDATA, 64'h1234_5678_9abc_def0);
    for (int i = 0; i < 32; i++) begin
      mt(5'h00, 64'(i));
      mt(5'h0a, 64'(i) << 13);
      mt(5'h02, 64'(i));
      mt(5'h03, 64'(i));
      mt(5'h05, 64'h0);
      send(18, 64'h0, 64'h0, 16'h0, 5'h0, 5'h0, 64'h0);
    end
    mt(5'h0a, 64'hdead_0000);
    mt(5'h00, 64'h3);
    send(17, 64'h0, 64'h0, 16'h0, 5'h0, 5'h0, 64'h0);
    mf(5'h0a);
    chk("tlb read tag", GPR_WDATA, 64'h6000);
    mf(5'h03);
    chk("tlb read odd page", GPR_WDATA, 64'h3);
    mt(5'h0a, 64'he000);
    send(20, 64'h0, 64'h0, 16'h0, 5'h0, 5'h0, 64'h0);
    chk("probe hit", PROBE_MISS, 64'h0);
    mf(5'h00);
    chk("probe index", GPR_WDATA, 64'h7);
    mt(5'h0a, 64'h1234_5000_0000_0000);
    send(20, 64'h0, 64'h0, 16'h0, 5'h0, 5'h0, 64'h0);
    chk("probe miss", PROBE_MISS, 64'h1);
    mt(5'h0a, 64'haa000);
    send(14, 64'h0, 64'h0, 16'h0, 5'h04, 5'h01, 64'h0);
    rnd = GPR_WDATA[4:0];
    send(19, 64'h0, 64'h0, 16'h0, 5'h0, 5'h0, 64'h0);
    mt(5'h00, (rnd == 5'h00) ? 64'h1f : 64'(rnd - 5'h01));
    send(17, 64'h0, 64'h0, 16'h0, 5'h0, 5'h0, 64'h0);
    mf(5'h0a);
    chk("random write tag", GPR_WDATA, 64'haa000);
    mt(5'h1e, 64'h2000);
    mt(5'h0c, 64'h6);
    chk("err level set", ERR_LEVEL, 64'h1);
    send(21, 64'h0, 64'h0, 16'h0, 5'h0, 5'h0, 64'h0);
    chk("resume pulse", RESUME_VALID, 64'h1);
    chk("resume from error", RESUME_PC, 64'h2000);
    chk("err level cleared", ERR_LEVEL, 64'h0);
    chk("exc level kept", EXC_LEVEL, 64'h1);
    send(21, 64'h0, 64'h0, 16'h0, 5'h0, 5'h0, 64'h0);
    chk("resume from trap", RESUME_PC, epc_exp);
    chk("exc level cleared", EXC_LEVEL, 64'h0);
    OP_VALID = 1'b0;
    @(posedge SYS_CLK);
    #1;
    chk("resume pulse ends", RESUME_VALID, 64'h0);
    chk("exceptions taken", trap_cnt, 64'(n_hits));
    chk("model gpr 7", model_u.gpr[7], 64'hffff_ffff_9abc_def0);
    finish_test();
  end
endmodule : tb_trap_and_sysctl_instr_exec
